// ---- hw/atx_pkg.sv ----
// Package with constants and carrier types for the drive command executor
package atx_pkg;
	// Command opcodes
	localparam logic [7:0] OP_IDLE_A = 8'h97;
	localparam logic [7:0] OP_IDLE_B = 8'hE3;
	localparam logic [7:0] OP_IDLE_IMM_A = 8'h95;
	localparam logic [7:0] OP_IDLE_IMM_B = 8'hE1;
	localparam logic [7:0] OP_NOP = 8'h00;
	localparam logic [7:0] OP_READ_BUF = 8'hE4;
	localparam logic [7:0] OP_READ_DMA = 8'hC8;
	localparam logic [7:0] OP_READ_MULT = 8'hC4;
	// Sector geometry: 512 bytes are 256 words of 16 bits
	localparam logic [8:0] SECTOR_WORDS = 9'h100;
	localparam logic [8:0] MAX_SECTORS = 9'h100;
	localparam int WORD_W = 16;
	localparam int FIFO_DEPTH = 4;
	// Power-down time base: 5 ms per count at a 4 ns clock
	localparam int IDLE_UNIT_US = 5000;
	localparam int CLK_PERIOD_NS = 4;
	localparam int IDLE_UNIT_CYC = (IDLE_UNIT_US * 1000) / CLK_PERIOD_NS;
	// Values after reset
	localparam logic [27:0] LBA_RST = 28'h000_0000;
	localparam logic [15:0] DATA_RST = 16'h0000;
	localparam logic [7:0] PD_RST = 8'h00;
	// Task file as written by the host
	typedef struct packed {
		logic [7:0] cmd;
		logic [7:0] count;
		logic [3:0] head;
		logic [7:0] cyl_hi;
		logic [7:0] cyl_lo;
		logic [7:0] sec_num;
	} atx_taskfile_t;
	// Status bits shown to the host
	typedef struct packed {
		logic busy;
		logic drq;
		logic err;
	} atx_status_t;
	// Error register bits
	typedef struct packed {
		logic abort;
		logic unc;
		logic corr;
	} atx_error_t;
	// Transfer flavour of the running command
	typedef enum logic [1:0] {MODE_PIO1, MODE_DMA, MODE_MULT} atx_mode_t;
endpackage : atx_pkg

// ---- hw/atx_cmd_exec.sv ----
// Command executor for idle, no-op and read commands, with its output FIFO
//
// Notes on behaviour
// - Idle: busy, idle mode, unbusy, interrupt
// - Non-zero count loads 5 ms power-down timer
// - Zero count disables automatic power-down
// - Idle immediate: same sequence, no timer
// - No-op always ends with aborted error
// - Read buffer returns buffer by PIO
// - DMA read 1..256 sectors, zero means 256
// - DMA read: busy, fill, request while data
// - DMA read interrupts once, at end or error
// - Success leaves last sector address
// - DMA error stops, failing address reported
// - Multiple read: data request per block
// - Count in sectors; full blocks, then remainder
// - Multiple read aborted when mode unset
// - Media error posted, block still transferred
// - Interrupt at each block start
// - Continue only after corrected error
// - PIO error keeps data and address
// - Per block: busy, load, request, unbusy, interrupt

module atx_fifo
	import atx_pkg::*;
#(
	parameter int WIDTH = WORD_W,
	parameter int DEPTH = FIFO_DEPTH
)
(
	input wire logic clk, // Device clock
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic clear, // Drop all contents
	input wire logic in_valid, // Word offered
	output logic in_ready, // Room for a word
	input wire logic [WIDTH-1:0] in_data, // Word in
	output logic out_valid, // Word available
	input wire logic out_ready, // Consumer takes it
	output logic [WIDTH-1:0] out_data // Oldest word
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH]; // Storage
	logic [AW-1:0] wr_ptr; // Write index
	logic [AW-1:0] rd_ptr; // Read index
	logic [AW:0] level; // Words held
	logic push; // Write this cycle
	logic pop; // Read this cycle

	// Full and empty come from the level, so they never lie
	assign in_ready = (level < (AW+1)'(DEPTH));
	assign out_valid = (level != '0);
	assign out_data = mem[rd_ptr];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// Pointer and level bookkeeping
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end
		else if (clear)
		begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			level <= '0;
		end
		else
		begin
			if (push)
				wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
			if (pop)
				rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
			level <= level + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// Storage carries no reset; contents are only read when valid
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_ptr] <= in_data;
	end
endmodule : atx_fifo

module atx_cmd_exec
	import atx_pkg::*;
#(
	parameter int IDLE_UNIT = IDLE_UNIT_CYC // Cycles per 5 ms count
)
(
	input wire logic clk, // Device clock, 250 MHz
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic cmd_wr, // Command write strobe
	input wire atx_taskfile_t cmd_tf, // Task file with the command
	input wire logic mult_enable, // Multiple reads enabled
	input wire logic [7:0] mult_block, // Block size, zero if never set
	output logic media_start, // Pulse: fetch sector at media_lba
	output logic [27:0] media_lba, // Sector to fetch
	input wire logic media_wr_valid, // Word from media into buffer
	input wire logic [15:0] media_wr_data, // That word
	input wire logic media_done, // Sector fetch finished
	input wire logic media_unc, // With uncorrectable error
	input wire logic media_corr, // With corrected error
	input wire logic host_rd_req, // Host wants a word (read strobe)
	input wire logic dma_ack, // Host DMA acknowledge
	output logic dma_req, // Device DMA request
	output logic [15:0] host_data, // Word to host
	output logic host_valid, // Pulse: host_data is new
	output atx_status_t status, // Busy, data request, error
	output atx_error_t error, // Error register bits
	output logic irq, // Pulse: interrupt to host
	output logic [27:0] lba_out, // Address registers
	output logic standby, // Low-power standby state
	output logic auto_pd_en // Automatic power-down enabled
);
	typedef enum logic [2:0] {ST_IDLE, ST_EXEC, ST_LOAD, ST_XFER, ST_END} atx_state_t;
	atx_state_t state; // Command sequencer
	atx_taskfile_t tf; // Latched task file
	atx_mode_t mode; // Flavour of the running read
	logic [15:0] sbuf [256]; // Sector buffer
	logic [7:0] wr_idx; // Media fill index
	logic [8:0] rd_idx; // Buffer words pushed into FIFO
	logic [8:0] host_cnt; // Words delivered this sector
	logic [8:0] remain; // Sectors left including current
	logic [8:0] blk_left; // Sectors left in current block
	logic [8:0] blk_size; // Block size in sectors
	logic first_in_blk; // Next load opens a block
	logic stop_pend; // Uncorrectable error seen in this block
	logic [27:0] err_lba; // Address of the failing sector
	logic [27:0] lba; // Current sector address
	logic [7:0] pd_reload; // Timer count to restart with
	logic [31:0] tick; // Cycles within one 5 ms unit
	logic [7:0] pd_left; // Units before standby
	logic fifo_in_valid; // Buffer word offered
	logic fifo_in_ready; // FIFO has room
	logic fifo_out_valid; // FIFO has a word
	logic fifo_pop; // Host takes a word
	logic [15:0] fifo_out_data; // Word leaving FIFO
	logic sector_end; // Last word of the sector delivered
	logic accept; // Command accepted this cycle

	assign accept = cmd_wr && (state == ST_IDLE);
	// Reads are paced by the host; DMA words also need the acknowledge
	assign fifo_pop = fifo_out_valid && host_rd_req && (mode != MODE_DMA || dma_ack);
	assign fifo_in_valid = (state == ST_XFER) && (rd_idx < SECTOR_WORDS);
	assign sector_end = fifo_pop && (host_cnt == SECTOR_WORDS - 9'h001);

	// Four words decouple the buffer read from the host strobes
	atx_fifo #(.WIDTH(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
		.clk(clk),
		.resetn(resetn),
		.clear(accept),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(sbuf[rd_idx[7:0]]),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	// Media fills the buffer; a failed sector's data stays in place
	always_ff @(posedge clk)
	begin
		if (media_wr_valid)
			sbuf[wr_idx] <= media_wr_data;
	end

	// Fill index restarts with every fetch
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
			wr_idx <= '0;
		else if (media_start)
			wr_idx <= '0;
		else if (media_wr_valid)
			wr_idx <= wr_idx + 1'b1;
	end

	// Main sequencer with status, interrupt and address tracking
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			state <= ST_IDLE;
			tf <= '0;
			mode <= MODE_PIO1;
			status <= '0;
			error <= '0;
			irq <= 1'b0;
			media_start <= 1'b0;
			lba <= LBA_RST;
			err_lba <= LBA_RST;
			remain <= '0;
			blk_left <= '0;
			blk_size <= '0;
			first_in_blk <= 1'b0;
			stop_pend <= 1'b0;
			rd_idx <= '0;
			host_cnt <= '0;
		end
		else
		begin
			irq <= 1'b0;
			media_start <= 1'b0;
			if (fifo_in_valid && fifo_in_ready)
				rd_idx <= rd_idx + 9'h001;
			if (fifo_pop)
				host_cnt <= host_cnt + 9'h001;
			unique case (state)
				ST_IDLE:
				begin
					if (accept)
					begin
						// Any command starts busy with a clean error register
						tf <= cmd_tf;
						status <= '{busy: 1'b1, drq: 1'b0, err: 1'b0};
						error <= '0;
						lba <= {cmd_tf.head, cmd_tf.cyl_hi, cmd_tf.cyl_lo, cmd_tf.sec_num};
						state <= ST_EXEC;
					end
				end
				ST_EXEC:
				begin
					rd_idx <= '0;
					host_cnt <= '0;
					stop_pend <= 1'b0;
					first_in_blk <= 1'b1;
					remain <= (tf.count == 8'h00) ? MAX_SECTORS : {1'b0, tf.count};
					blk_size <= {1'b0, mult_block};
					if (tf.cmd == OP_IDLE_A || tf.cmd == OP_IDLE_B || tf.cmd == OP_IDLE_IMM_A
						|| tf.cmd == OP_IDLE_IMM_B)
						state <= ST_END;
					else if (tf.cmd == OP_READ_BUF)
					begin
						// No media fetch: the present buffer goes out as one sector
						mode <= MODE_PIO1;
						remain <= 9'h001;
						status <= '{busy: 1'b0, drq: 1'b1, err: 1'b0};
						irq <= 1'b1;
						state <= ST_XFER;
					end
					else if (tf.cmd == OP_READ_DMA)
					begin
						mode <= MODE_DMA;
						media_start <= 1'b1;
						state <= ST_LOAD;
					end
					else if (tf.cmd == OP_READ_MULT && mult_enable && mult_block != 8'h00)
					begin
						mode <= MODE_MULT;
						media_start <= 1'b1;
						blk_left <= ({1'b0, tf.count} != 9'h000 && {1'b0, tf.count} < {1'b0, mult_block})
							? {1'b0, tf.count} : {1'b0, mult_block};
						state <= ST_LOAD;
					end
					else
					begin
						// No-op, unset multiple mode and unknown opcodes end aborted
						error.abort <= 1'b1;
						status.err <= 1'b1;
						state <= ST_END;
					end
				end
				ST_LOAD:
				begin
					if (media_done)
					begin
						rd_idx <= '0;
						host_cnt <= '0;
						if (media_unc)
						begin
							error.unc <= 1'b1;
							err_lba <= lba;
						end
						if (media_corr)
							error.corr <= 1'b1;
						if (mode == MODE_DMA && media_unc)
						begin
							// Stop at the failing sector; lba already names it
							status <= '{busy: 1'b1, drq: 1'b0, err: 1'b1};
							state <= ST_END;
						end
						else
						begin
							status.busy <= 1'b0;
							status.drq <= 1'b1;
							if (mode == MODE_MULT && media_unc)
								stop_pend <= 1'b1;
							if (media_unc || (mode == MODE_MULT && media_corr))
								status.err <= 1'b1;
							// PIO interrupts at block start only; DMA waits for the end
							if (mode == MODE_MULT && first_in_blk)
								irq <= 1'b1;
							first_in_blk <= 1'b0;
							state <= ST_XFER;
						end
					end
				end
				ST_XFER:
				begin
					if (sector_end)
					begin
						if (remain == 9'h001 || (mode == MODE_MULT && blk_left == 9'h001 && stop_pend))
						begin
							if (stop_pend)
								lba <= err_lba;
							status.drq <= 1'b0;
							if (mode == MODE_DMA)
							begin
								status.busy <= 1'b1;
								state <= ST_END;
							end
							else
								state <= ST_IDLE;
						end
						else
						begin
							// Next sector; drop request only at a block edge or in DMA
							lba <= lba + 28'h000_0001;
							remain <= remain - 9'h001;
							media_start <= 1'b1;
							state <= ST_LOAD;
							if (mode == MODE_MULT && blk_left != 9'h001)
								blk_left <= blk_left - 9'h001;
							else
							begin
								status <= '{busy: 1'b1, drq: 1'b0, err: status.err};
								first_in_blk <= 1'b1;
								blk_left <= (remain - 9'h001 < blk_size) ? remain - 9'h001 : blk_size;
							end
						end
					end
				end
				ST_END:
				begin
					status.busy <= 1'b0;
					irq <= 1'b1;
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Host word register and DMA request; request stands while data waits
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			host_data <= DATA_RST;
			host_valid <= 1'b0;
			dma_req <= 1'b0;
		end
		else
		begin
			host_valid <= fifo_pop;
			if (fifo_pop)
				host_data <= fifo_out_data;
			dma_req <= (state == ST_XFER) && (mode == MODE_DMA) && fifo_out_valid && !sector_end
				|| (state == ST_XFER) && (mode == MODE_DMA) && fifo_in_valid;
		end
	end

	// Power-down timer; it only runs while no command is active
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			pd_reload <= PD_RST;
			pd_left <= PD_RST;
			tick <= '0;
			auto_pd_en <= 1'b0;
			standby <= 1'b0;
		end
		else if (accept)
		begin
			// Every command restarts the timer and wakes the drive
			tick <= '0;
			pd_left <= pd_reload;
			standby <= 1'b0;
			if (cmd_tf.cmd == OP_IDLE_A || cmd_tf.cmd == OP_IDLE_B)
			begin
				pd_reload <= cmd_tf.count;
				pd_left <= cmd_tf.count;
				auto_pd_en <= (cmd_tf.count != 8'h00);
			end
		end
		else if (auto_pd_en && !standby && state == ST_IDLE)
		begin
			if (tick == 32'(IDLE_UNIT - 1))
			begin
				tick <= '0;
				pd_left <= pd_left - 8'h01;
				if (pd_left == 8'h01)
					standby <= 1'b1;
			end
			else
				tick <= tick + 32'h0000_0001;
		end
	end

	assign media_lba = lba;
	assign lba_out = lba;

	// Checks on the sequencing
	idle_irq_a: assert property (@(posedge clk) disable iff (!resetn)
		accept && (cmd_tf.cmd == OP_IDLE_IMM_A) |-> ##3 irq && !status.busy)
		else $error("idle immediate did not interrupt in time");
	idle_pd_a: assert property (@(posedge clk) disable iff (!resetn)
		accept && (cmd_tf.cmd == OP_IDLE_A) |=> auto_pd_en == ($past(cmd_tf.count) != 8'h00) && !standby)
		else $error("idle count did not set power-down enable");
	idle_off_a: assert property (@(posedge clk) disable iff (!resetn)
		!auto_pd_en |=> !$rose(standby))
		else $error("standby entered with power-down disabled");
	nop_abort_a: assert property (@(posedge clk) disable iff (!resetn)
		accept && (cmd_tf.cmd == OP_NOP) |-> ##2 error.abort && status.err ##1 irq)
		else $error("no-op was not aborted");
	mult_abort_a: assert property (@(posedge clk) disable iff (!resetn)
		accept && (cmd_tf.cmd == OP_READ_MULT) && !mult_enable |-> ##2 error.abort && !media_start)
		else $error("multiple read without mode not aborted");
	dma_noirq_a: assert property (@(posedge clk) disable iff (!resetn)
		(mode == MODE_DMA) && (state == ST_LOAD || state == ST_XFER) |-> !irq)
		else $error("DMA read interrupted mid-transfer");
	dma_stop_a: assert property (@(posedge clk) disable iff (!resetn)
		(state == ST_LOAD) && media_done && media_unc && (mode == MODE_DMA)
		|=> status.err ##1 (irq && $stable(lba_out)))
		else $error("DMA error did not stop at failing sector");
	dreq_data_a: assert property (@(posedge clk) disable iff (!resetn)
		dma_req |-> mode == MODE_DMA && status.drq)
		else $error("DMA request without data phase");
	pop_ack_a: assert property (@(posedge clk) disable iff (!resetn)
		$rose(host_valid) && (mode == MODE_DMA) |-> $past(dma_ack) && $past(host_rd_req))
		else $error("DMA word delivered without acknowledge");
	blk_irq_a: assert property (@(posedge clk) disable iff (!resetn)
		irq && (mode == MODE_MULT) && (state == ST_XFER) |-> status.drq && !status.busy)
		else $error("block interrupt without data request");
	sector_len_a: assert property (@(posedge clk) disable iff (!resetn)
		sector_end |-> rd_idx == SECTOR_WORDS)
		else $error("sector length not 256 words");
	wake_a: assert property (@(posedge clk) disable iff (!resetn)
		accept |=> !standby)
		else $error("command did not leave standby");
	dma_end_c: cover property (@(posedge clk) disable iff (!resetn)
		(mode == MODE_DMA) && (state == ST_END) ##1 irq);
	mult_blk_c: cover property (@(posedge clk) disable iff (!resetn)
		(mode == MODE_MULT) && irq && (state == ST_XFER) && status.err);
	standby_c: cover property (@(posedge clk) disable iff (!resetn) $rose(standby));
	rdbuf_c: cover property (@(posedge clk) disable iff (!resetn)
		(mode == MODE_PIO1) && sector_end);
endmodule : atx_cmd_exec

// ---- testbench/atx_media_model.sv ----
// Behavioural flash side of the executor: streams one sector of words per fetch
module atx_media_model
	import atx_pkg::*;
(
	input wire logic clk, // Device clock
	input wire logic resetn, // Asynchronous reset, active low
	input wire logic start, // Fetch request pulse
	input wire logic [27:0] lba, // Sector to fetch
	input wire logic [27:0] unc_lba, // Sector that fails hard
	input wire logic [27:0] corr_lba, // Sector with a fixed error
	output logic wr_valid, // Word strobe
	output logic [15:0] wr_data, // Word into the buffer
	output logic done, // Fetch finished pulse
	output logic unc, // Hard error, valid with done
	output logic corr // Corrected error, valid with done
);
	timeunit 1ns;
	timeprecision 100ps;
	logic busy; // Fetch running
	logic [8:0] idx; // Word index inside the sector
	logic [27:0] cur; // Latched sector address

	// Word i of a sector carries the low address byte and i, so order slips show up
	always_ff @(posedge clk or negedge resetn)
	begin
		if (!resetn)
		begin
			busy <= 1'b0;
			idx <= 9'h000;
			cur <= 28'h000_0000;
			wr_valid <= 1'b0;
			wr_data <= 16'h0000;
			done <= 1'b0;
			unc <= 1'b0;
			corr <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			unc <= 1'b0;
			corr <= 1'b0;
			wr_valid <= 1'b0;
			// Idle data line shows the inverse, so stale words never look valid
			wr_data <= ~wr_data;
			if (start)
			begin
				busy <= 1'b1;
				idx <= 9'h000;
				cur <= lba;
			end
			else if (busy && idx < SECTOR_WORDS)
			begin
				wr_valid <= 1'b1;
				wr_data <= {cur[7:0], idx[7:0]};
				idx <= idx + 9'h001;
			end
			else if (busy)
			begin
				// Error flags are only meaningful beside the done pulse
				busy <= 1'b0;
				done <= 1'b1;
				unc <= (cur == unc_lba);
				corr <= (cur == corr_lba);
			end
		end
	end
endmodule : atx_media_model

// ---- testbench/atx_cmd_exec_tb.sv ----
// Self-checking bench for the drive command executor
module atx_cmd_exec_tb
	import atx_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int UNIT = 8; // Short power-down time base for simulation
	logic clk = 1'b0; // Device clock
	logic resetn = 1'b0; // Reset, active low
	logic cmd_wr = 1'b0; // Command strobe
	atx_taskfile_t cmd_tf = '0; // Task file
	logic mult_enable = 1'b0; // Multiple reads enabled
	logic [7:0] mult_block = 8'h00; // Block size
	logic host_rd_req = 1'b0; // Host read strobe
	logic dma_ack = 1'b0; // Host DMA acknowledge
	logic [27:0] unc_lba = 28'hFFF_FFFF; // Sector made to fail hard
	logic [27:0] corr_lba = 28'hFFF_FFFF; // Sector made to need correction
	logic media_start, media_wr_valid, media_done, media_unc, media_corr, dma_req, host_valid, irq;
	logic standby, auto_pd_en;
	logic [27:0] media_lba, lba_out;
	logic [15:0] media_wr_data, host_data;
	atx_status_t status;
	atx_error_t error;
	int n_mismatch = 0; // Failed comparisons
	int compares = 0; // All comparisons
	int cyc = 0; // Cycle counter for the hang guard
	logic saw_req = 1'b0; // DMA request seen during the last run

	atx_cmd_exec #(.IDLE_UNIT(UNIT)) u_atx_cmd_exec (.clk(clk), .resetn(resetn), .cmd_wr(cmd_wr), .cmd_tf(cmd_tf),
		.mult_enable(mult_enable), .mult_block(mult_block), .media_start(media_start), .media_lba(media_lba),
		.media_wr_valid(media_wr_valid), .media_wr_data(media_wr_data), .media_done(media_done),
		.media_unc(media_unc), .media_corr(media_corr), .host_rd_req(host_rd_req), .dma_ack(dma_ack),
		.dma_req(dma_req), .host_data(host_data), .host_valid(host_valid), .status(status), .error(error),
		.irq(irq), .lba_out(lba_out), .standby(standby), .auto_pd_en(auto_pd_en));

	atx_media_model u_atx_media_model (.clk(clk), .resetn(resetn), .start(media_start), .lba(media_lba),
		.unc_lba(unc_lba), .corr_lba(corr_lba), .wr_valid(media_wr_valid), .wr_data(media_wr_data),
		.done(media_done), .unc(media_unc), .corr(media_corr));

	// Clock at 250 MHz
	always #2 clk = ~clk;

	// Hang guard, well above the few thousand cycles the tests need
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 40000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end

	// Compare one value and count it
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	// Print counts and verdict, then stop
	task automatic report_and_stop();
		$display("compares %0d n_mismatch %0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : report_and_stop

	// Write one command; callers only come here with the sequencer idle
	task automatic send_cmd(input logic [7:0] op, input logic [7:0] cnt, input logic [27:0] lba);
		@(posedge clk);
		cmd_wr <= 1'b1;
		cmd_tf <= '{cmd: op, count: cnt, head: lba[27:24], cyl_hi: lba[23:16], cyl_lo: lba[15:8], sec_num: lba[7:0]};
		@(posedge clk);
		cmd_wr <= 1'b0;
	endtask : send_cmd

	// Follow a command to idle: take words, check their order, count interrupts
	task automatic run(input logic [27:0] lba0, input logic dma, output int words, output int nirq,
		output int t_irq);
		int t;
		logic [27:0] l;
		l = lba0;
		words = 0;
		nirq = 0;
		t_irq = 0;
		saw_req = 1'b0;
		for (t = 1; t < 8000; t++)
		begin
			@(posedge clk);
			// Host stalls one cycle in five so the FIFO fills and refuses
			host_rd_req <= (t % 5 != 0);
			dma_ack <= dma;
			#1;
			if (dma_req === 1'b1)
				saw_req = 1'b1;
			if (irq === 1'b1)
			begin
				nirq++;
				if (t_irq == 0)
					t_irq = t;
			end
			if (host_valid === 1'b1)
			begin
				check(host_data, {l[7:0], words[7:0]});
				words++;
				if (words % 256 == 0)
					l++;
			end
			if (status.busy === 1'b0 && status.drq === 1'b0)
				break;
		end
		// A command that never settles counts against the run
		if (t == 8000)
			n_mismatch++;
		host_rd_req <= 1'b0;
		dma_ack <= 1'b0;
	endtask : run

	// Let n edges pass, then step past the edge
	task automatic idle_wait(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : idle_wait

	// Main sequence
	initial
	begin
		int w, n, ti, i;
		logic [7:0] ops [4];
		ops = '{OP_IDLE_IMM_A, OP_IDLE_IMM_B, OP_NOP, 8'h50};
		idle_wait(6);
		resetn <= 1'b1;
		idle_wait(1);
		check({status, error, irq, standby, auto_pd_en}, 0);
		// Immediate idle, no-op and an unknown opcode
		for (i = 0; i < 4; i++)
		begin
			send_cmd(ops[i], 8'h05, 28'h000_0000);
			run(28'h000_0000, 1'b0, w, n, ti);
			check(ti, 2);
			check(n, 1);
			check(error.abort, (i >= 2));
			check(auto_pd_en, 1'b0);
		end
		$display("test idle_immediate_and_abort done");
		// Idle with a timer, then idle with the timer off
		send_cmd(OP_IDLE_A, 8'h02, 28'h000_0000);
		run(28'h000_0000, 1'b0, w, n, ti);
		check(ti, 2);
		check(auto_pd_en, 1'b1);
		idle_wait(10);
		check(standby, 1'b0);
		idle_wait(20);
		check(standby, 1'b1);
		send_cmd(OP_IDLE_B, 8'h00, 28'h000_0000);
		run(28'h000_0000, 1'b0, w, n, ti);
		check(n, 1);
		idle_wait(40);
		check(standby, 1'b0);
		check(auto_pd_en, 1'b0);
		$display("test idle_timer done");
		// DMA read, clean and with a hard error, then read back the buffer
		send_cmd(OP_READ_DMA, 8'h02, 28'h123_4567);
		run(28'h123_4567, 1'b1, w, n, ti);
		check(w, 512);
		check(n, 1);
		check(lba_out, 28'h123_4568);
		check(saw_req, 1'b1);
		unc_lba <= 28'h234_5679;
		send_cmd(OP_READ_DMA, 8'h03, 28'h234_5678);
		run(28'h234_5678, 1'b1, w, n, ti);
		check(n, 1);
		check(lba_out, 28'h234_5679);
		check({status.err, error.unc}, 2'b11);
		send_cmd(OP_READ_BUF, 8'h00, 28'h000_0000);
		run(28'h234_5679, 1'b0, w, n, ti);
		check(w, 256);
		check(n, 1);
		check(saw_req, 1'b0);
		$display("test dma_and_buffer done");
		// Multiple read refused without a block size or while disabled
		unc_lba <= 28'hFFF_FFFF;
		for (i = 0; i < 2; i++)
		begin
			mult_enable <= (i == 1);
			mult_block <= (i == 0) ? 8'h02 : 8'h00;
			send_cmd(OP_READ_MULT, 8'h04, 28'h000_0010);
			run(28'h000_0010, 1'b0, w, n, ti);
			check({w[15:0], error.abort}, {16'h0000, 1'b1});
		end
		// Uneven count with a corrected error, then a hard error in the first block
		mult_block <= 8'h02;
		corr_lba <= 28'h000_0012;
		send_cmd(OP_READ_MULT, 8'h05, 28'h000_0010);
		run(28'h000_0010, 1'b0, w, n, ti);
		check(w, 1280);
		check(n, 3);
		check(error.corr, 1'b1);
		corr_lba <= 28'hFFF_FFFF;
		unc_lba <= 28'h000_0021;
		send_cmd(OP_READ_MULT, 8'h04, 28'h000_0020);
		run(28'h000_0020, 1'b0, w, n, ti);
		check(w, 512);
		check(n, 1);
		check(lba_out, 28'h000_0021);
		check(error.unc, 1'b1);
		$display("test read_multiple done");
		report_and_stop();
	end
endmodule : atx_cmd_exec_tb
